/* flash_self_defs.svh */
`ifndef FLASH_SELF_DEFS_SVH
`define FLASH_SELF_DEFS_SVH

// register byte offsets on the axi4-lite slave
`define OFS_ADDR_LOW 8'h00
`define OFS_ADDR_HIGH 8'h04
`define OFS_DATA_LOW 8'h08
`define OFS_DATA_HIGH 8'h0c
`define OFS_CONTROL 8'h10
`define OFS_UNLOCK 8'h14
`define OFS_STATUS 8'h18
`define OFS_CONFIG 8'h1c

// control register fields
`define CTL_READ_BIT 0
`define CTL_WRITE_BIT 1
`define CTL_WEN_BIT 2
`define CTL_ABORT_BIT 3
`define CTL_SPACE_BIT 7

// status register fields
`define STS_DONE_BIT 0
`define STS_STALL_BIT 1
`define STS_SERIAL_OFF_BIT 2

// config register fields (protect word, kept until full erase or power-on)
`define CFG_PERMIT_BIT 0
`define CFG_PROT_LOW_BIT 1
`define CFG_PROT_HIGH_BIT 2
`define CFG_DATA_PROT_BIT 3

// unlock key bytes
`define UNLOCK_KEY1 8'h55
`define UNLOCK_KEY2 8'haa

// timing: one instruction cycle is one clock
`define READ_CYCLES 2
`define PREP_CYCLES 2
`define WRITE_TIME_NS 2000
`define CLK_PERIOD_NS 5
`define WRITE_CYCLES ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWRT_CYCLES 64

// memory geometry
`define MEM_AW 13
`define MEM_DW 14

`endif

/* flash_self_pkg.sv */
`default_nettype none
package flash_self_pkg;
    typedef enum logic [2:0] {
        st_idle,
        st_read,
        st_prep,
        st_write
    } op_state_t;

    typedef struct packed {
        logic [12:0] addr;
        logic [13:0] data;
    } mem_req_t;

    typedef struct packed {
        logic code_protect_high;
        logic code_protect_low;
        logic program_write_permit;
        logic data_protect_bit;
    } protect_t;
endpackage
`default_nettype wire

/* flash_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_self_defs.svh"
// program array, registered read data
module flash_mem (
    // clock
    input wire logic aclk,
    // access
    input wire logic wr_en,
    input wire flash_self_pkg::mem_req_t req,
    output logic [13:0] rdata
);
    logic [13:0] mem [0:(1<<`MEM_AW)-1];

    // single port: a write and a read never overlap in the controller
    always_ff @(posedge aclk) begin
        if (wr_en) begin
            mem[req.addr] <= req.data;
        end
        rdata <= mem[req.addr];
    end
endmodule
`default_nettype wire

/* cycle_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// down counter: load a count, done pulses when it reaches one
module cycle_timer #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic busy,
    output logic done
);
    logic [W-1:0] cnt_reg;

    assign busy = (cnt_reg != '0);
    assign done = (cnt_reg == W'(1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= count;
        end else if (busy) begin
            cnt_reg <= cnt_reg - W'(1);
        end
    end
endmodule
`default_nettype wire

/* program_flash_self_access.sv */
// How it works
// - program read takes exactly two cycles
// - data bytes hold last read value
// - write halts core, peripherals keep running
// - resume after second no-op following trigger
// - permit bit clear refuses program writes
// - trigger needs gate set by earlier write
// - clearing gate does not abort write
// - write needs 55h then aah unlock
// - two prep cycles follow the trigger
// - word is fourteen bits over two bytes
// - done clears trigger, sets done flag
// - no automatic verify of written data
// - power-up clears gate, timer blocks writes
// - data protect never gates internal access
// - data protect alone disables serial, code protect not needed
// - code protect never blocks internal reads
// - protection stays until full erase or power-on
// - triggers set-only, hardware clears them
// - reset during write sets abort flag
// - space select frozen during operation
`timescale 1ns/1ps
`default_nettype none
`include "flash_self_defs.svh"
module program_flash_self_access #(
    parameter int WRITE_CYCLES = `WRITE_CYCLES,
    parameter int PWRT_CYCLES = `PWRT_CYCLES
) (
    // clock and resets
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    input wire logic pwrt_enable,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // protect configuration from the erase path
    input wire logic cfg_load,
    input wire flash_self_pkg::protect_t cfg_in,
    input wire logic full_erase,
    // core and serial port
    output logic core_stall,
    output logic serial_access_off
);
    localparam int TW = 16;

    logic [7:0] addr_low_reg;
    logic [4:0] addr_high_reg;
    logic [7:0] data_low_reg;
    logic [5:0] data_high_reg;
    logic space_reg;
    logic wen_reg;
    logic rd_reg;
    logic wr_reg;
    logic abort_reg;
    logic done_reg;
    logic [1:0] unlock_reg;
    logic cp_reg;
    flash_self_pkg::protect_t cfg_reg;
    flash_self_pkg::op_state_t state_reg;
    logic [TW-1:0] pwrt_reg;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;

    // write channel capture: address and data taken in either order
    wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire lane0 = w_strb_reg[0];
    wire [7:0] wb = w_data_reg[7:0];
    wire hit_al = do_write && lane0 && aw_addr_reg == `OFS_ADDR_LOW;
    wire hit_ah = do_write && lane0 && aw_addr_reg == `OFS_ADDR_HIGH;
    wire hit_dl = do_write && lane0 && aw_addr_reg == `OFS_DATA_LOW;
    wire hit_dh = do_write && lane0 && aw_addr_reg == `OFS_DATA_HIGH;
    wire hit_ctl = do_write && lane0 && aw_addr_reg == `OFS_CONTROL;
    wire hit_unl = do_write && lane0 && aw_addr_reg == `OFS_UNLOCK;
    wire hit_sts = do_write && lane0 && aw_addr_reg == `OFS_STATUS;

    // operation control
    wire busy = state_reg != flash_self_pkg::st_idle;
    wire start_rd = hit_ctl && wb[`CTL_READ_BIT] && !busy && !rd_reg
        && wb[`CTL_SPACE_BIT];
    // gate must already be set; unlock must be complete; power-up timer idle
    wire wr_allowed = wen_reg && unlock_reg == 2'd2 && pwrt_reg == '0;
    wire start_wr = hit_ctl && wb[`CTL_WRITE_BIT] && !busy && wr_allowed
        && space_reg && wb[`CTL_SPACE_BIT];
    // permit bit clear refuses the write: the array is never touched
    wire permit = cfg_reg.program_write_permit;
    wire [TW-1:0] rd_load = TW'(`READ_CYCLES);
    wire [TW-1:0] pr_load = TW'(`PREP_CYCLES);
    wire [TW-1:0] wr_load = TW'(WRITE_CYCLES);

    logic t_load;
    logic [TW-1:0] t_count;
    logic t_busy;
    logic t_done;
    always_comb begin
        t_load = 1'b0;
        t_count = rd_load;
        if (start_rd) begin
            t_load = 1'b1;
        end else if (start_wr) begin
            t_load = 1'b1;
            t_count = pr_load;
        end else if (state_reg == flash_self_pkg::st_prep && t_done) begin
            t_load = 1'b1;
            t_count = wr_load;
        end
    end

    cycle_timer #(.W(TW)) timer_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(t_load),
        .count(t_count),
        .busy(t_busy),
        .done(t_done)
    );

    // array access: reads ignore every protect bit, 14-bit word
    flash_self_pkg::mem_req_t mreq;
    logic [13:0] mem_rdata;
    assign mreq.addr = {addr_high_reg, addr_low_reg};
    assign mreq.data = {data_high_reg, data_low_reg};
    wire mem_we = state_reg == flash_self_pkg::st_write && t_done && permit;

    flash_mem mem_i (
        .aclk(aclk),
        .wr_en(mem_we),
        .req(mreq),
        .rdata(mem_rdata)
    );

    wire rd_finish = state_reg == flash_self_pkg::st_read && t_done;
    wire wr_finish = state_reg == flash_self_pkg::st_write && t_done;

    // sequencer; no compare after write, firmware verifies by reading back
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= flash_self_pkg::st_idle;
        end else begin
            unique case (state_reg)
                flash_self_pkg::st_idle: begin
                    if (start_rd) state_reg <= flash_self_pkg::st_read;
                    else if (start_wr) state_reg <= flash_self_pkg::st_prep;
                end
                flash_self_pkg::st_read: begin
                    if (t_done) state_reg <= flash_self_pkg::st_idle;
                end
                flash_self_pkg::st_prep: begin
                    if (t_done) state_reg <= flash_self_pkg::st_write;
                end
                flash_self_pkg::st_write: begin
                    if (t_done) state_reg <= flash_self_pkg::st_idle;
                end
                default: state_reg <= flash_self_pkg::st_idle;
            endcase
        end
    end

    // the core sits still for the write phase only; after it the next
    // fetch is the instruction behind the second prep no-op
    assign core_stall = state_reg == flash_self_pkg::st_write;

    // serial port lockout: data protect cleared, with or without code protect
    assign serial_access_off = cp_reg && !cfg_reg.data_protect_bit;

    // protect word: a load can only add protection, a cleared bit stays
    // cleared, so only a full erase or power-on reset drops it
    always_ff @(posedge aclk) begin
        if (!por_n || full_erase) begin
            cfg_reg <= '{code_protect_high: 1'b1, code_protect_low: 1'b1,
                program_write_permit: 1'b1, data_protect_bit: 1'b1};
            cp_reg <= 1'b0;
        end else if (cfg_load) begin
            cfg_reg <= flash_self_pkg::protect_t'(cfg_reg & cfg_in);
            cp_reg <= cp_reg || !(cfg_in.code_protect_low && cfg_in.code_protect_high)
                || !cfg_in.data_protect_bit;
        end
    end

    // power-up timer: por only, writes blocked while it runs
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            pwrt_reg <= TW'(PWRT_CYCLES);
        end else if (pwrt_reg != '0) begin
            pwrt_reg <= pwrt_enable ? pwrt_reg - TW'(1) : '0;
        end
    end

    // address, data, space: kept over core resets, lost only at power-on
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            addr_low_reg <= 8'h00;
            addr_high_reg <= 5'h00;
            data_low_reg <= 8'h00;
            data_high_reg <= 6'h00;
            space_reg <= 1'b0;
        end else begin
            if (hit_al) addr_low_reg <= wb;
            if (hit_ah) addr_high_reg <= wb[4:0];
            if (rd_finish) begin
                {data_high_reg, data_low_reg} <= mem_rdata;
            end else begin
                if (hit_dl) data_low_reg <= wb;
                if (hit_dh) data_high_reg <= wb[5:0];
            end
            if (hit_ctl && !busy) space_reg <= wb[`CTL_SPACE_BIT];
        end
    end

    // gate and abort control bits and done flag
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            wen_reg <= 1'b0;
            abort_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (!aresetn) begin
            wen_reg <= 1'b0;
            if (busy) abort_reg <= 1'b1;
        end else begin
            if (hit_ctl) begin
                wen_reg <= wb[`CTL_WEN_BIT];
                abort_reg <= wb[`CTL_ABORT_BIT];
            end
            // set wins over a same-cycle clear
            if (wr_finish) done_reg <= 1'b1;
            else if (hit_sts && wb[`STS_DONE_BIT]) done_reg <= 1'b0;
        end
    end

    // triggers are set-only; hardware clears them at the end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            unlock_reg <= 2'd0;
        end else begin
            if (start_rd) rd_reg <= 1'b1;
            else if (rd_finish) rd_reg <= 1'b0;
            if (start_wr) wr_reg <= 1'b1;
            else if (wr_finish) wr_reg <= 1'b0;
            // any other register write breaks the unlock run
            if (hit_unl && wb == `UNLOCK_KEY1) unlock_reg <= 2'd1;
            else if (hit_unl && wb == `UNLOCK_KEY2 && unlock_reg == 2'd1) unlock_reg <= 2'd2;
            else if (do_write) unlock_reg <= 2'd0;
        end
    end

    // axi4-lite write side: one outstanding write
    assign s_axi_awready = !aw_hold_reg;
    assign s_axi_wready = !w_hold_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = 2'b00;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_hold_reg) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_hold_reg) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) bvalid_reg <= 1'b1;
            if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
            end
        end
    end
    // axi4-lite read side: unmapped reads return zero with okay
    logic [31:0] rd_mux;
    always_comb begin
        unique case ({s_axi_araddr[7:2], 2'b00})
            `OFS_ADDR_LOW: rd_mux = {24'h000000, addr_low_reg};
            `OFS_ADDR_HIGH: rd_mux = {27'h0000000, addr_high_reg};
            `OFS_DATA_LOW: rd_mux = {24'h000000, data_low_reg};
            `OFS_DATA_HIGH: rd_mux = {26'h0000000, data_high_reg};
            `OFS_CONTROL: rd_mux = {24'h000000, space_reg, 3'h0, abort_reg,
                wen_reg, wr_reg, rd_reg};
            `OFS_STATUS: rd_mux = {29'h00000000, serial_access_off, core_stall, done_reg};
            `OFS_CONFIG: rd_mux = {28'h0000000, cfg_reg.data_protect_bit,
                cfg_reg.code_protect_high, cfg_reg.code_protect_low,
                cfg_reg.program_write_permit};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = 2'b00;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* flash_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// watches the bus handshakes and the length of the core stall
module flash_checker #(
    parameter int WRITE_CYCLES = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // core side
    input wire logic core_stall
);
    logic [15:0] stall_cnt;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // cycles the core has been held so far; a mid-run reset restarts it
    always_ff @(posedge aclk) begin
        if (!aresetn || !core_stall) begin
            stall_cnt <= 16'h0000;
        end else begin
            stall_cnt <= stall_cnt + 16'h0001;
        end
    end
    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    AST_BDROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_BANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
    AST_RANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    AST_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken while response pending");
    AST_STALL_LEN: assert property ($fell(core_stall) && $past(aresetn) |->
        stall_cnt == WRITE_CYCLES) else $error("stall length wrong");
    AST_STALL_MAX: assert property (stall_cnt <= WRITE_CYCLES)
        else $error("stall too long");
endmodule
bind program_flash_self_access flash_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .core_stall);
`default_nettype wire

/* core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// stand-in for the core: counts retired instructions
module core_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // stall in, retired count out
    input wire logic core_stall,
    output logic [15:0] pc
);
    // nothing retires while held, and it carries on from where it stopped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc <= 16'h0000;
        end else if (!core_stall) begin
            pc <= pc + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* program_flash_self_access_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_self_defs.svh"
module program_flash_self_access_test;
    localparam int WR = 8;
    localparam int PW = 60;
    localparam int K = WR + 20;
    logic aclk, aresetn, por_n, pwrt_enable, cfg_load, full_erase;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic core_stall, serial_access_off;
    logic [15:0] pc;
    flash_self_pkg::protect_t cfg_in;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    program_flash_self_access #(.WRITE_CYCLES(WR), .PWRT_CYCLES(PW)) dut_u (
        .aclk, .aresetn, .por_n, .pwrt_enable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_load, .cfg_in, .full_erase,
        .core_stall, .serial_access_off);
    core_model core_u (.aclk, .aresetn, .core_stall, .pc);
    task conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task check_bit(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    // address and data are offered together; each is dropped once taken
    task axi_write(input logic [7:0] a, input logic [31:0] d);
        bit aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok));
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        check(32'(s_axi_bresp), 32'h00000000, "write response");
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task axi_read(input logic [7:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        check(32'(s_axi_rresp), 32'h00000000, "read response");
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task reg_is(input logic [7:0] a, input logic [31:0] exp);
        axi_read(a, rd);
        check(rd, exp, "register");
    endtask
    task set_addr(input logic [12:0] a);
        axi_write(`OFS_ADDR_LOW, {24'h000000, a[7:0]});
        axi_write(`OFS_ADDR_HIGH, {27'h0000000, a[12:8]});
    endtask
    task program_word(input logic [12:0] a, input logic [13:0] d, input bit gate, input bit unl);
        set_addr(a);
        axi_write(`OFS_DATA_LOW, {24'h000000, d[7:0]});
        axi_write(`OFS_DATA_HIGH, {26'h0000000, d[13:8]});
        axi_write(`OFS_CONTROL, gate ? 32'h00000084 : 32'h00000080);
        if (unl) begin
            axi_write(`OFS_UNLOCK, 32'h00000055);
            axi_write(`OFS_UNLOCK, 32'h000000aa);
        end
        axi_write(`OFS_CONTROL, 32'h00000086);
    endtask
    // fetch takes two cycles; the data bytes show it at the edge that ends the second
    task readback(input logic [12:0] a, input logic [13:0] d);
        set_addr(a);
        axi_write(`OFS_CONTROL, 32'h00000081);
        repeat (3) @(posedge aclk);
        reg_is(`OFS_DATA_LOW, {24'h000000, d[7:0]});
        reg_is(`OFS_DATA_HIGH, {26'h0000000, d[13:8]});
        reg_is(`OFS_DATA_LOW, {24'h000000, d[7:0]});
    endtask
    task watch_stall(input int e);
        logic [15:0] pc0;
        int cnt;
        pc0 = pc;
        cnt = 0;
        repeat (K) begin
            if (core_stall === 1'b1) cnt++;
            @(posedge aclk);
        end
        check(32'(cnt), 32'(e), "stall cycles");
        check(32'(pc - pc0), 32'(K - cnt), "retired");
    endtask
    task set_cfg(input logic [3:0] v);
        cfg_in <= v;
        cfg_load <= 1'b1;
        @(posedge aclk);
        cfg_load <= 1'b0;
        @(posedge aclk);
    endtask
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // hang guard, far above the several hundred cycles the run needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        {aresetn, por_n, cfg_load, full_erase, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'h1;
        pwrt_enable = 1'b1;
        cfg_in = 4'hf;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        set_cfg(4'hf);
        reg_is(`OFS_CONTROL, 32'h00000000);
        program_word(13'h0123, 14'h2a5c, 1'b1, 1'b1);
        watch_stall(0);
        repeat (PW) @(posedge aclk);
        program_word(13'h0123, 14'h2a5c, 1'b1, 1'b0);
        watch_stall(0);
        program_word(13'h0123, 14'h2a5c, 1'b0, 1'b1);
        watch_stall(0);
        reg_is(`OFS_STATUS, 32'h00000000);
        program_word(13'h0123, 14'h2a5c, 1'b1, 1'b1);
        watch_stall(WR);
        reg_is(`OFS_CONTROL, 32'h00000084);
        reg_is(`OFS_STATUS, 32'h00000001);
        axi_write(`OFS_STATUS, 32'h00000001);
        reg_is(`OFS_STATUS, 32'h00000000);
        readback(13'h0123, 14'h2a5c);
        // gate dropped while the write is still running
        program_word(13'h1f00, 14'h1533, 1'b1, 1'b1);
        axi_write(`OFS_CONTROL, 32'h00000080);
        reg_is(`OFS_CONTROL, 32'h00000082);
        repeat (K) @(posedge aclk);
        readback(13'h1f00, 14'h1533);
        set_cfg(4'hd);
        program_word(13'h0123, 14'h0abc, 1'b1, 1'b1);
        watch_stall(WR);
        readback(13'h0123, 14'h2a5c);
        set_cfg(4'ha);
        check_bit(serial_access_off, 1'b1, "serial off");
        readback(13'h1f00, 14'h1533);
        set_cfg(4'hf);
        check_bit(serial_access_off, 1'b1, "serial off kept");
        full_erase <= 1'b1;
        @(posedge aclk);
        full_erase <= 1'b0;
        repeat (2) @(posedge aclk);
        check_bit(serial_access_off, 1'b0, "serial after erase");
        axi_write(`OFS_CONFIG, 32'h00000000);
        reg_is(`OFS_CONFIG, 32'h0000000f);
        // core reset in mid-write leaves the abort mark
        program_word(13'h0040, 14'h3fff, 1'b1, 1'b1);
        for (n = 0; n < K && core_stall !== 1'b1; n++) @(posedge aclk);
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        reg_is(`OFS_CONTROL, 32'h00000088);
        conclude();
    end
endmodule
`default_nettype wire
